/* File: core/cgep_regs.sv */
// Function
// - subchannel disable at zero lets enabled slots run subchannels.
// - subchannel disable at one masks every per-slot subchannel enable.
// - with subchannels disabled the descriptor region is reported free and never looked up.
// - group transmit enable at zero masks every transmit slot enable.
// - while group transmit is disabled the transmit data output is released.
// - group transmit enable at one activates each transmit slot whose map bit is set.
// - group receive enable at zero masks every receive slot enable.
// - group receive enable at one activates each receive slot whose map bit is set.
// - the group gates are a mask only and never alter stored map bits.
// - protection enable at one is stored but no address checking happens.
// - the 12-bit upper protection bound is stored in bits 27 to 16.
// - the 12-bit lower protection bound is stored in bits 11 to 0.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module cgep_regs (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire cgep_pkg::cgep_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] tx_slot_active,
    output logic [31:0] rx_slot_active,
    output logic [31:0] sub_slot_active,
    output logic sub_region_free,
    output logic tx_data_oe_n,
    output logic protection_enable,
    output logic [11:0] protection_upper_bound,
    output logic [11:0] protection_lower_bound
);
    cgep_pkg::cgep_state_type state_reg;
    cgep_pkg::cgep_state_type state_next;
    logic setup;
    logic access;
    logic known;
    logic [31:0] rd;
    logic tx_on;
    logic rx_on;
    logic sub_off;

    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable & state_reg.pready;

    always_comb begin
        state_next = state_reg;
        known = 1'b1;
        rd = cgep_pkg::ZERO_WORD;
        unique case (apb_req.paddr)
            cgep_pkg::OFF_GROUP_CFG: rd = state_reg.group_cfg;
            cgep_pkg::OFF_PROT: rd = state_reg.prot;
            cgep_pkg::OFF_TX_MAP: rd = state_reg.tx_map;
            cgep_pkg::OFF_RX_MAP: rd = state_reg.rx_map;
            cgep_pkg::OFF_SUB_MAP: rd = state_reg.sub_map;
            cgep_pkg::OFF_STATUS: rd = {31'h0000_0000, state_reg.sub_region_free};
            default: known = 1'b0;
        endcase
        // no wait state: ready rises at the edge that starts the first access cycle
        state_next.pready = setup;
        if (setup) begin
            state_next.pslverr = ~known;
            state_next.prdata = (apb_req.pwrite | ~known) ? cgep_pkg::ZERO_WORD : rd;
        end else if (access) begin
            state_next.pready = 1'b0;
            state_next.pslverr = 1'b0;
            if (apb_req.pwrite && known) begin
                unique case (apb_req.paddr)
                    cgep_pkg::OFF_GROUP_CFG:
                        state_next.group_cfg = apb_req.pwdata & cgep_pkg::GRP_CFG_MASK;
                    cgep_pkg::OFF_PROT:
                        state_next.prot = apb_req.pwdata & cgep_pkg::PROT_MASK;
                    cgep_pkg::OFF_TX_MAP: state_next.tx_map = apb_req.pwdata;
                    cgep_pkg::OFF_RX_MAP: state_next.rx_map = apb_req.pwdata;
                    cgep_pkg::OFF_SUB_MAP: state_next.sub_map = apb_req.pwdata;
                    default: state_next.pslverr = 1'b0;
                endcase
            end
        end
        tx_on = state_reg.group_cfg[cgep_pkg::GRP_TX_EN_BIT];
        rx_on = state_reg.group_cfg[cgep_pkg::GRP_RX_EN_BIT];
        sub_off = state_reg.group_cfg[cgep_pkg::GRP_SUB_DIS_BIT];
        // masks only; stored maps stay untouched
        state_next.tx_active = state_reg.tx_map & {cgep_pkg::NUM_SLOTS{tx_on}};
        state_next.rx_active = state_reg.rx_map & {cgep_pkg::NUM_SLOTS{rx_on}};
        state_next.sub_active = state_reg.sub_map & state_reg.tx_map & state_reg.rx_map
            & {cgep_pkg::NUM_SLOTS{~sub_off}} & {cgep_pkg::NUM_SLOTS{tx_on | rx_on}};
        state_next.sub_region_free = sub_off;
        state_next.tx_data_oe_n = ~tx_on;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
            state_reg.tx_data_oe_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign tx_slot_active = state_reg.tx_active;
    assign rx_slot_active = state_reg.rx_active;
    assign sub_slot_active = state_reg.sub_active;
    assign sub_region_free = state_reg.sub_region_free;
    assign tx_data_oe_n = state_reg.tx_data_oe_n;
    // no checking logic hangs off these fields
    assign protection_enable = state_reg.prot[cgep_pkg::PROT_EN_BIT];
    assign protection_upper_bound = state_reg.prot[cgep_pkg::PROT_HI_LSB +: 12];
    assign protection_lower_bound = state_reg.prot[cgep_pkg::PROT_LO_LSB +: 12];
endmodule
`default_nettype wire

/* File: shared/cgep_pkg.sv */
package cgep_pkg;
    localparam int unsigned NUM_SLOTS = 32;
    localparam logic [11:0] OFF_GROUP_CFG = 12'h000;
    localparam logic [11:0] OFF_PROT = 12'h004;
    localparam logic [11:0] OFF_TX_MAP = 12'h008;
    localparam logic [11:0] OFF_RX_MAP = 12'h00C;
    localparam logic [11:0] OFF_SUB_MAP = 12'h010;
    localparam logic [11:0] OFF_STATUS = 12'h014;
    localparam int unsigned GRP_RX_EN_BIT = 0;
    localparam int unsigned GRP_TX_EN_BIT = 1;
    localparam int unsigned GRP_SUB_DIS_BIT = 2;
    localparam logic [31:0] GRP_CFG_MASK = 32'h0000_0007;
    localparam logic [31:0] PROT_MASK = 32'h8FFF_0FFF;
    localparam int unsigned PROT_EN_BIT = 31;
    localparam int unsigned PROT_HI_LSB = 16;
    localparam int unsigned PROT_LO_LSB = 0;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [31:0] group_cfg;
        logic [31:0] prot;
        logic [31:0] tx_map;
        logic [31:0] rx_map;
        logic [31:0] sub_map;
        logic [31:0] tx_active;
        logic [31:0] rx_active;
        logic [31:0] sub_active;
        logic sub_region_free;
        logic tx_data_oe_n;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cgep_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cgep_apb_req_type;
endpackage

/* File: testbench/cgep_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module cgep_monitor (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire cgep_pkg::cgep_apb_req_type apb_req,
    input wire logic pready,
    input wire logic [31:0] tx_slot_active,
    input wire logic [31:0] rx_slot_active,
    input wire logic [31:0] sub_slot_active,
    input wire logic sub_region_free,
    input wire logic tx_data_oe_n,
    input wire logic protection_enable,
    input wire logic [11:0] protection_upper_bound,
    input wire logic [11:0] protection_lower_bound
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic wr;
    logic wr_g;
    logic wr_p;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && pready;
    assign wr_g = wr && apb_req.paddr == 12'h000;
    assign wr_p = wr && apb_req.paddr == 12'h004;
    sub_mask_a: assert property (sub_region_free |-> sub_slot_active == '0)
        else $error("sub active while disabled");
    oe_gate_a: assert property (tx_data_oe_n |-> tx_slot_active == '0)
        else $error("tx active while released");
    tx_off_a: assert property (wr_g && !apb_req.pwdata[1] |=> ##1 tx_data_oe_n)
        else $error("tx output not released");
    rx_off_a: assert property (wr_g && !apb_req.pwdata[0] |=> ##1 rx_slot_active == '0)
        else $error("rx not masked");
    sub_free_a: assert property (wr_g && apb_req.pwdata[2] |=> ##1 sub_region_free)
        else $error("region not free");
    upper_bound_a: assert property (wr_p |=> protection_upper_bound == $past(apb_req.pwdata[27:16]))
        else $error("upper bound wrong");
    lower_bound_a: assert property (wr_p |=> protection_lower_bound == $past(apb_req.pwdata[11:0]))
        else $error("lower bound wrong");
    prot_store_a: assert property (wr_p |=> protection_enable == $past(apb_req.pwdata[31]))
        else $error("enable bit wrong");
endmodule
bind cgep_regs cgep_monitor u_mon (.clk_sys, .resetn, .apb_req, .pready, .tx_slot_active,
    .rx_slot_active, .sub_slot_active, .sub_region_free, .tx_data_oe_n, .protection_enable,
    .protection_upper_bound, .protection_lower_bound);
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    cgep_pkg::cgep_apb_req_type req = '0;
    logic [31:0] prdata, tx_a, rx_a, sb_a, r;
    logic pready, pslverr, sfree, oe_n, pen, err;
    logic [11:0] phi, plo;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    always #10 clk_sys = ~clk_sys;
    cgep_regs DUT (.clk_sys, .resetn, .apb_req(req), .prdata, .pready, .pslverr,
        .tx_slot_active(tx_a), .rx_slot_active(rx_a), .sub_slot_active(sb_a),
        .sub_region_free(sfree), .tx_data_oe_n(oe_n), .protection_enable(pen),
        .protection_upper_bound(phi), .protection_lower_bound(plo));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{1'h1, 1'h0, w, a, d};
        @(posedge clk_sys);
        req.penable <= 1'h1;
        @(posedge clk_sys iff pready);
        r = prdata;
        err = pslverr;
        req <= '0;
        repeat (2) @(negedge clk_sys);
    endtask
    task stop_test();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        resetn <= 1'h1;
        xf(1'h1, 12'h008, 32'hA5A5_5A5A);
        xf(1'h1, 12'h00C, 32'h0F0F_F0F0);
        xf(1'h1, 12'h010, 32'hFFFF_0000);
        chk(tx_a | rx_a, 32'h0);
        chk(oe_n, 32'h1);
        xf(1'h1, 12'h000, 32'h3);
        chk(tx_a, 32'hA5A5_5A5A);
        chk(rx_a, 32'h0F0F_F0F0);
        chk(sb_a, 32'h0505_0000);
        xf(1'h1, 12'h000, 32'h7);
        chk(sb_a, 32'h0);
        xf(1'h0, 12'h014, 32'h0);
        chk(r[0], 32'h1);
        xf(1'h1, 12'h000, 32'h0);
        xf(1'h0, 12'h008, 32'h0);
        chk(r, 32'hA5A5_5A5A);
        xf(1'h1, 12'h004, 32'hFFFF_FFFF);
        chk({pen, phi, plo}, 32'h01FF_FFFF);
        xf(1'h0, 12'h004, 32'h0);
        chk(r, 32'h8FFF_0FFF);
        xf(1'h1, 12'h004, 32'h0123_0456);
        chk({pen, phi, plo}, 32'h0012_3456);
        xf(1'h0, 12'h020, 32'h0);
        chk(err, 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
